// ===== design/gas_aperture_size.sv
// Aperture size register and the masked aperture base address bits it governs.
`timescale 1ns/1ps
// Behaviour
// RULE1 - Size bit n governs base address bit 22+n, one to one.
// RULE2 - Base bit with cleared mask bit reads zero and ignores writes.
// RULE3 - Base bit with set mask bit is ordinary read/write storage.
// RULE4 - Size field resets to zero, giving the 256 MB aperture.
// RULE5 - Codes 100000, 110000, 111000 mean 128, 64, 32 MB.
// RULE6 - Codes 111100, 111110, 111111 mean 16, 8, 4 MB.
// RULE7 - Code 111000 keeps bits 24:22 zero, bits 27:25 programmable.
// RULE8 - Boot firmware writes the size field before bus enumeration.
// RULE9 - Boot firmware programs a size smaller than the maximum.
// RULE10 - Size register bits 7:6 read zero and ignore writes.
module gas_aperture_size (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_rvalid,
  output logic      [5:0]  aperture_size_mask,
  output logic      [5:0]  aperture_base_hi,
  output logic      [8:0]  aperture_size_mb
);
  logic [5:0]  mask_nxt;
  logic [8:0]  size_mb_nxt;
  logic [31:0] rdata_nxt;
  logic        base_hit;

  function automatic logic [3:0] count_ones(input logic [5:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int k = 0; k < gas_pkg::SIZE_W; k++) begin
      n = n + {3'b000, v[k]};
    end
    return n;
  endfunction : count_ones

  // Only the low six bits are stored; bits 7:6 have no storage.
  always_comb begin
    mask_nxt = aperture_size_mask;
    if (cfg_wr && cfg_addr == gas_pkg::SIZE_OFF && cfg_be[0]) begin
      mask_nxt = cfg_wdata[gas_pkg::SIZE_W-1:0]; // RULE10
    end
  end

  // Each set mask bit halves the aperture, from 256 MB down to 4 MB.
  always_comb begin
    size_mb_nxt = gas_pkg::SIZE_MB_MAX >> count_ones(mask_nxt); // RULE5 RULE6
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aperture_size_mask <= gas_pkg::SIZE_RST; // RULE4
      aperture_size_mb   <= gas_pkg::SIZE_MB_MAX;
    end else begin
      aperture_size_mask <= mask_nxt;
      aperture_size_mb   <= size_mb_nxt;
    end
  end

  assign base_hit = cfg_wr && cfg_addr == gas_pkg::BASE_OFF;

  for (genvar i = 0; i < gas_pkg::SIZE_W; i++) begin : g_base
    localparam int LANE = (gas_pkg::BASE_LSB + i) / 8;
    gas_mask_cell u_cell (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .keep_nxt (mask_nxt[i]),                       // RULE1 RULE2 RULE3 RULE7
      .wr_en    (base_hit && cfg_be[LANE]),
      .wr_bit   (cfg_wdata[gas_pkg::BASE_LSB + i]),
      .stored_r (aperture_base_hi[i])
    );
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (cfg_rd) begin
      case (cfg_addr)
        gas_pkg::SIZE_OFF: rdata_nxt = {26'h000_0000, aperture_size_mask}; // RULE10
        gas_pkg::BASE_OFF: rdata_nxt = {4'h0, aperture_base_hi, 22'h00_0000};
        default:           rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata  <= 32'h0000_0000;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rdata  <= rdata_nxt;
      cfg_rvalid <= cfg_rd;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_RESET_MAX: assert property ( // RULE4
    !$past(rst_n) |-> (aperture_size_mask == 6'h00 && aperture_size_mb == 9'h100 && aperture_base_hi == 6'h00))
    else $error("Size field not at maximum aperture after reset.");

  AST_MASKED_ZERO: assert property ( // RULE2
    (aperture_base_hi & ~aperture_size_mask) == 6'h00)
    else $error("Masked base bit is not zero.");

  // Write side: the size field, and the base bits it gates bit by bit.
  AST_MASK_CLEARS_BIT: assert property ( // RULE1
    (cfg_wr && cfg_addr == gas_pkg::SIZE_OFF && cfg_be[0] && !base_hit)
      |=> aperture_base_hi == ($past(aperture_base_hi) & $past(cfg_wdata[gas_pkg::SIZE_W-1:0])))
    else $error("Size write did not gate the matching base bits.");

  AST_SIZE_WRITE: assert property ( // RULE1
    (cfg_wr && cfg_addr == gas_pkg::SIZE_OFF && cfg_be[0])
      |=> aperture_size_mask == $past(cfg_wdata[gas_pkg::SIZE_W-1:0]))
    else $error("Size field did not take the written value.");

  AST_SIZE_LANE_HOLD: assert property ( // RULE10
    (cfg_wr && cfg_addr == gas_pkg::SIZE_OFF && !cfg_be[0])
      |=> $stable(aperture_size_mask))
    else $error("Size field changed on a write without byte lane 0.");

  AST_MASK_RAISE_ZERO: assert property ( // RULE2
    (cfg_wr && cfg_addr == gas_pkg::SIZE_OFF && cfg_be[0])
      |=> (aperture_base_hi & ~$past(aperture_size_mask)) == 6'h00)
    else $error("Newly enabled base bit did not start at zero.");

  AST_BASE_WRITE: assert property ( // RULE3
    (cfg_wr && cfg_addr == gas_pkg::BASE_OFF && cfg_be[3:2] == 2'h3)
      |=> aperture_base_hi == ($past(cfg_wdata[gas_pkg::BASE_MSB:gas_pkg::BASE_LSB]) & aperture_size_mask))
    else $error("Enabled base bits did not take the written value.");

  AST_BASE_LANE2_WRITE: assert property ( // RULE3
    (cfg_wr && cfg_addr == gas_pkg::BASE_OFF && cfg_be[2])
      |=> aperture_base_hi[1:0] == ($past(cfg_wdata[23:22]) & aperture_size_mask[1:0]))
    else $error("Base bits 23:22 did not follow byte lane 2.");

  AST_BASE_LANE2_HOLD: assert property ( // RULE3
    (cfg_wr && cfg_addr == gas_pkg::BASE_OFF && !cfg_be[2])
      |=> aperture_base_hi[1:0] == $past(aperture_base_hi[1:0]))
    else $error("Base bits 23:22 changed without byte lane 2.");

  AST_BASE_LANE3_WRITE: assert property ( // RULE3
    (cfg_wr && cfg_addr == gas_pkg::BASE_OFF && cfg_be[3])
      |=> aperture_base_hi[5:2] == ($past(cfg_wdata[27:24]) & aperture_size_mask[5:2]))
    else $error("Base bits 27:24 did not follow byte lane 3.");

  AST_BASE_LANE3_HOLD: assert property ( // RULE3
    (cfg_wr && cfg_addr == gas_pkg::BASE_OFF && !cfg_be[3])
      |=> aperture_base_hi[5:2] == $past(aperture_base_hi[5:2]))
    else $error("Base bits 27:24 changed without byte lane 3.");

  AST_IDLE_HOLD: assert property ( // RULE3
    !cfg_wr
      |=> $stable(aperture_base_hi) && $stable(aperture_size_mask) && $stable(aperture_size_mb))
    else $error("Register state changed without a write.");

  AST_EXAMPLE_32MB: assert property ( // RULE7
    (aperture_size_mask == gas_pkg::CODE_32MB && cfg_wr && cfg_addr == gas_pkg::BASE_OFF && cfg_be[3:2] == 2'h3
      && cfg_wdata[gas_pkg::BASE_MSB:gas_pkg::BASE_LSB] == 6'h3f)
      |=> aperture_base_hi == gas_pkg::CODE_32MB)
    else $error("Bits 27:25 not programmable or 24:22 not zero.");

  AST_EXAMPLE_LOW_ZERO: assert property ( // RULE7
    aperture_size_mask == gas_pkg::CODE_32MB |-> aperture_base_hi[2:0] == 3'h0)
    else $error("Base bits 24:22 not zero under the 32 MB code.");

  // Size decode: each code of the table maps to its aperture in megabytes.
  AST_DECODE_LARGE: assert property ( // RULE5
    (aperture_size_mask == gas_pkg::CODE_128MB |-> aperture_size_mb == 9'h080) and
    (aperture_size_mask == gas_pkg::CODE_64MB |-> aperture_size_mb == 9'h040) and
    (aperture_size_mask == gas_pkg::CODE_32MB |-> aperture_size_mb == 9'h020))
    else $error("Large aperture code decoded wrongly.");

  AST_DECODE_SMALL: assert property ( // RULE6
    (aperture_size_mask == gas_pkg::CODE_16MB |-> aperture_size_mb == 9'h010) and
    (aperture_size_mask == gas_pkg::CODE_8MB |-> aperture_size_mb == 9'h008) and
    (aperture_size_mask == gas_pkg::CODE_4MB |-> aperture_size_mb == 9'h004))
    else $error("Small aperture code decoded wrongly.");

  AST_DECODE_MAX: assert property ( // RULE4
    aperture_size_mask == gas_pkg::SIZE_RST |-> aperture_size_mb == gas_pkg::SIZE_MB_MAX)
    else $error("Cleared size field did not give the largest aperture.");

  AST_SIZE_POWER: assert property ( // RULE6
    $onehot(aperture_size_mb) && aperture_size_mb >= 9'h004 && aperture_size_mb <= gas_pkg::SIZE_MB_MAX)
    else $error("Aperture size is not a power of two from 4 MB to 256 MB.");

  // Read side: one registered answer per request, zero when idle.
  AST_RSVD_READ: assert property ( // RULE10
    (cfg_rd && cfg_addr == gas_pkg::SIZE_OFF)
      |=> cfg_rvalid && cfg_rdata[31:6] == 26'h0 && cfg_rdata[5:0] == $past(aperture_size_mask))
    else $error("Size register read returned reserved bits or wrong field.");

  AST_BASE_READ: assert property ( // RULE3
    (cfg_rd && cfg_addr == gas_pkg::BASE_OFF)
      |=> cfg_rvalid && cfg_rdata == {4'h0, $past(aperture_base_hi), 22'h00_0000})
    else $error("Base register read returned the wrong bits.");

  AST_UNMAPPED_READ: assert property ( // RULE10
    (cfg_rd && cfg_addr != gas_pkg::SIZE_OFF && cfg_addr != gas_pkg::BASE_OFF)
      |=> cfg_rvalid && cfg_rdata == 32'h0000_0000)
    else $error("Unmapped read returned nonzero data.");

  AST_READ_PULSE: assert property ( // RULE3
    cfg_rd |=> cfg_rvalid)
    else $error("Read valid missing one cycle after a read.");

  AST_READ_IDLE: assert property ( // RULE10
    !cfg_rd |=> !cfg_rvalid && cfg_rdata == 32'h0000_0000)
    else $error("Read data or valid shown without a read.");

  AST_RESET_READ: assert property ( // RULE4
    !$past(rst_n) |-> !cfg_rvalid && cfg_rdata == 32'h0000_0000)
    else $error("Read port not idle after reset.");

  COV_SET_4MB: cover property (
    cfg_wr && cfg_addr == gas_pkg::SIZE_OFF && cfg_be[0] ##1 aperture_size_mb == 9'h004);
  COV_BASE_KEEP: cover property (
    aperture_size_mask == gas_pkg::CODE_32MB ##1 aperture_base_hi == gas_pkg::CODE_32MB);
  COV_SHRINK_CLEAR: cover property (
    aperture_base_hi[5] ##1 !aperture_size_mask[5]);
  COV_LANE_SPLIT: cover property (
    cfg_wr && cfg_addr == gas_pkg::BASE_OFF && cfg_be[3:2] == 2'h1);
  COV_READ_SMALL: cover property (
    cfg_rd && cfg_addr == gas_pkg::SIZE_OFF && aperture_size_mask == gas_pkg::CODE_4MB);
endmodule : gas_aperture_size

// ===== design/gas_pkg.sv
// Constants shared by the aperture size mask logic.
package gas_pkg;
  localparam logic [7:0] SIZE_OFF     = 8'hb4;
  localparam logic [7:0] BASE_OFF     = 8'h10;
  localparam int         SIZE_W       = 6;
  localparam int         BASE_LSB     = 22;
  localparam int         BASE_MSB     = 27;
  localparam int         RSVD_MSB     = 7;
  localparam int         RSVD_LSB     = 6;
  localparam logic [5:0] SIZE_RST     = 6'h00;
  localparam logic [8:0] SIZE_MB_MAX  = 9'h100;
  localparam logic [5:0] CODE_128MB   = 6'h20;
  localparam logic [5:0] CODE_64MB    = 6'h30;
  localparam logic [5:0] CODE_32MB    = 6'h38;
  localparam logic [5:0] CODE_16MB    = 6'h3c;
  localparam logic [5:0] CODE_8MB     = 6'h3e;
  localparam logic [5:0] CODE_4MB     = 6'h3f;
endpackage : gas_pkg

// ===== design/gas_mask_cell.sv
// One aperture base bit whose storage is enabled by its size mask bit.
`timescale 1ns/1ps
module gas_mask_cell (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic keep_nxt,
  input  wire logic wr_en,
  input  wire logic wr_bit,
  output logic      stored_r
);
  logic stored_nxt;

  // A cleared mask bit forces the bit to zero and drops writes.
  always_comb begin
    if (!keep_nxt) begin
      stored_nxt = 1'b0;
    end else if (wr_en) begin
      stored_nxt = wr_bit;
    end else begin
      stored_nxt = stored_r;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stored_r <= 1'b0;
    end else begin
      stored_r <= stored_nxt;
    end
  end
endmodule : gas_mask_cell

// ===== tb/gas_testbench.sv
// Self-checking bench for the aperture size register and its masked base bits.
`timescale 1ns/1ps
module testbench;
  logic        clk_sys   = 1'b0;
  logic        rst_n     = 1'b0;
  logic [7:0]  cfg_addr  = 8'h00;
  logic        cfg_wr    = 1'b0;
  logic        cfg_rd    = 1'b0;
  logic [3:0]  cfg_be    = 4'h0;
  logic [31:0] cfg_wdata = 32'h0000_0000;
  logic [31:0] cfg_rdata;
  logic        cfg_rvalid;
  logic [5:0]  aperture_size_mask;
  logic [5:0]  aperture_base_hi;
  logic [8:0]  aperture_size_mb;
  int          mismatches  = 0;
  int          check_count = 0;
  logic [5:0]  codes [6]   = '{gas_pkg::CODE_128MB, gas_pkg::CODE_64MB, gas_pkg::CODE_32MB,
                               gas_pkg::CODE_16MB, gas_pkg::CODE_8MB, gas_pkg::CODE_4MB};

  always #12.5 clk_sys = ~clk_sys;

  gas_aperture_size uut (
    .clk_sys            (clk_sys),
    .rst_n              (rst_n),
    .cfg_addr           (cfg_addr),
    .cfg_wr             (cfg_wr),
    .cfg_rd             (cfg_rd),
    .cfg_be             (cfg_be),
    .cfg_wdata          (cfg_wdata),
    .cfg_rdata          (cfg_rdata),
    .cfg_rvalid         (cfg_rvalid),
    .aperture_size_mask (aperture_size_mask),
    .aperture_base_hi   (aperture_base_hi),
    .aperture_size_mb   (aperture_size_mb)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge clk_sys);
    cfg_addr  = a;
    cfg_be    = be;
    cfg_wdata = d;
    cfg_wr    = 1'b1;
    @(negedge clk_sys);
    cfg_wr    = 1'b0;
  endtask : wr

  // Read data and its valid pulse must be present at the falling edge one clock after the request.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(negedge clk_sys);
    cfg_addr = a;
    cfg_rd   = 1'b1;
    @(negedge clk_sys);
    cfg_rd   = 1'b0;
    chk({31'h0000_0000, cfg_rvalid}, 32'h0000_0001);
    chk(cfg_rdata, exp);
  endtask : rd

  task automatic close_out;
    $display("Checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    chk({23'h00_0000, aperture_size_mb}, 32'h0000_0100);
    rd(8'hb4, 32'h0000_0000);
    wr(8'h10, 4'hf, 32'hffff_ffff);
    chk({26'h000_0000, aperture_base_hi}, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      wr(8'hb4, 4'h1, {24'h00_0000, 2'b11, codes[i]});
      wr(8'h10, 4'hc, 32'hffff_ffff);
      chk({26'h000_0000, aperture_size_mask}, {26'h000_0000, codes[i]});
      chk({23'h00_0000, aperture_size_mb}, 32'h0000_0100 >> (i + 1));
      chk({26'h000_0000, aperture_base_hi}, {26'h000_0000, codes[i]});
      rd(8'hb4, {26'h000_0000, codes[i]});
      rd(8'h10, {4'h0, codes[i], 22'h00_0000});
    end
    wr(gas_pkg::SIZE_OFF, 4'he, 32'h0000_0000);
    chk({26'h000_0000, aperture_size_mask}, {26'h000_0000, gas_pkg::CODE_4MB});
    wr(gas_pkg::BASE_OFF, 4'h8, 32'h0000_0000);
    chk({26'h000_0000, aperture_base_hi}, 32'h0000_0003);
    wr(gas_pkg::BASE_OFF, 4'h4, 32'h0080_0000);
    chk({26'h000_0000, aperture_base_hi}, 32'h0000_0002);
    rd(gas_pkg::BASE_OFF, 32'h0080_0000);
    wr(8'h10, 4'hc, 32'h0a80_0000);
    chk({26'h000_0000, aperture_base_hi}, 32'h0000_002a);
    wr(8'hb4, 4'h1, 32'h0000_0000);
    chk({26'h000_0000, aperture_base_hi}, 32'h0000_0000);
    wr(gas_pkg::SIZE_OFF, 4'h1, {26'h000_0000, gas_pkg::CODE_16MB});
    wr(gas_pkg::BASE_OFF, 4'hc, 32'hffff_ffff);
    chk({26'h000_0000, aperture_base_hi}, {26'h000_0000, gas_pkg::CODE_16MB});
    @(negedge clk_sys);
    rst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    chk({26'h000_0000, aperture_size_mask}, 32'h0000_0000);
    chk({23'h00_0000, aperture_size_mb}, 32'h0000_0100);
    chk({26'h000_0000, aperture_base_hi}, 32'h0000_0000);
    rd(gas_pkg::SIZE_OFF, 32'h0000_0000);
    close_out();
  end
endmodule : testbench
